//--- logic/buck_seq_pkg.sv
// constants, timing and state codes for the buck start-up and fault sequencer
package buck_seq_pkg;
    localparam int CLK_KHZ          = 25000;
    // detection pulse train: 10 kHz at 1 % duty
    localparam int PROBE_FREQ_HZ    = 10000;
    localparam int PROBE_DUTY_PCT   = 1;
    localparam int PROBE_PERIOD_CYC = (CLK_KHZ * 1000) / PROBE_FREQ_HZ;
    localparam int PROBE_HIGH_CYC   = (PROBE_PERIOD_CYC * PROBE_DUTY_PCT) / 100;
    // four crossings of the supply threshold mean the input is ready
    localparam logic [2:0] CROSS_NEEDED = 3'h4;
    // soft-start and hiccup off time, both in microseconds
    localparam int SOFT_START_US    = 3000;
    localparam int HICCUP_OFF_US    = 3000;
    localparam int SOFT_START_CYC   = (SOFT_START_US * CLK_KHZ) / 1000;
    localparam int HICCUP_OFF_CYC   = (HICCUP_OFF_US * CLK_KHZ) / 1000;
    localparam int SS_STEPS         = 256;
    // under-voltage qualification delay, 30 us, least time rounds up
    localparam int UV_DELAY_US      = 30;
    localparam int UV_DELAY_CYC     = (UV_DELAY_US * CLK_KHZ + 999) / 1000;
    localparam logic [9:0] UV_DELAY = 10'(UV_DELAY_CYC);
    // soft-start code where it crosses the modulator ramp valley
    localparam logic [7:0] SS_VALLEY = 8'h20;
    localparam logic [7:0] SS_FULL   = 8'hff;
    localparam logic [2:0] FAULT_LIMIT = 3'h4;
    localparam logic [2:0] UVFB_LIMIT  = 3'h4;
    // synchroniser bit positions
    localparam int IN_ABOVE = 0;
    localparam int IN_LOW   = 1;
    localparam int IN_OC    = 2;
    localparam int IN_SWUV  = 3;
    localparam int IN_LNUV  = 4;
    localparam int IN_PWM   = 5;
    localparam int IN_W     = 6;

    typedef enum logic [5:0] {
        ST_DETECT   = 6'h01,
        ST_SOFTST   = 6'h02,
        ST_RUN      = 6'h04,
        ST_HICCUP   = 6'h08,
        ST_LATCHED  = 6'h10,
        ST_SHUTDOWN = 6'h20
    } state_type;
endpackage

//--- logic/buck_fault_sequencer.sv
// start-up, soft-start, hiccup and latch-off sequencing for the buck controller
`timescale 1ns/100ps
module buck_fault_sequencer #(
    parameter int SS_TIME_CYC   = buck_seq_pkg::SOFT_START_CYC,
    parameter int HICCUP_CYC    = buck_seq_pkg::HICCUP_OFF_CYC
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // comparator levels from the analog front end, asynchronous
    input  wire logic       ops_above_threshold,
    input  wire logic       ops_pulled_low,
    input  wire logic       overcurrent_guard,
    input  wire logic       switcher_feedback_low,
    input  wire logic       linear_feedback_low,
    input  wire logic       modulator_pwm,
    // drive and status
    output logic            high_side_gate_drive,
    output logic            switching_enable,
    output logic [7:0]      soft_start_level,
    output logic            input_supply_detect,
    output logic            latched_off
);
    localparam int SS_STEP_CYC = SS_TIME_CYC / buck_seq_pkg::SS_STEPS;
    localparam logic [16:0] SS_STEP_LAST = 17'(SS_STEP_CYC - 1);
    localparam logic [16:0] HICCUP_LAST  = 17'(HICCUP_CYC - 1);
    localparam logic [11:0] PROBE_LAST   = 12'(buck_seq_pkg::PROBE_PERIOD_CYC - 1);
    localparam logic [11:0] PROBE_HIGH   = 12'(buck_seq_pkg::PROBE_HIGH_CYC);
    localparam int          W = buck_seq_pkg::IN_W;

    buck_seq_pkg::state_type state_q, state_d;
    logic [W-1:0] sync1_q, sync2_q;
    logic         above_prev_q, above_prev_d;
    logic [2:0]   cross_q, cross_d;
    logic [11:0]  probe_q, probe_d;
    logic [16:0]  timer_q, timer_d;
    logic [7:0]   ss_q, ss_d;
    logic [9:0]   swuv_cnt_q, swuv_cnt_d;
    logic [9:0]   lnuv_cnt_q, lnuv_cnt_d;
    logic [2:0]   fault_q, fault_d;
    logic [2:0]   uvfb_q, uvfb_d;
    logic         cause_uvfb_q, cause_uvfb_d;
    logic         gate_q, gate_d;
    logic         sw_en_q, sw_en_d;
    logic         detect_q, detect_d;
    logic         latch_q, latch_d;
    logic         above_s, low_s, oc_s, swuv_s, lnuv_s, pwm_s;
    logic         crossing, swuv_fault, lnuv_fault;

    assign above_s = sync2_q[buck_seq_pkg::IN_ABOVE];
    assign low_s   = sync2_q[buck_seq_pkg::IN_LOW];
    assign oc_s    = sync2_q[buck_seq_pkg::IN_OC];
    assign swuv_s  = sync2_q[buck_seq_pkg::IN_SWUV];
    assign lnuv_s  = sync2_q[buck_seq_pkg::IN_LNUV];
    assign pwm_s   = sync2_q[buck_seq_pkg::IN_PWM];
    assign crossing   = above_s ^ above_prev_q;
    assign swuv_fault = (swuv_cnt_q == buck_seq_pkg::UV_DELAY);
    assign lnuv_fault = (lnuv_cnt_q == buck_seq_pkg::UV_DELAY);

    always_comb begin
        state_d      = state_q;
        above_prev_d = above_s;
        cross_d      = cross_q;
        // parked at the wrap so every new pulse train opens with a full-width pulse
        probe_d      = PROBE_LAST;
        timer_d      = timer_q;
        ss_d         = ss_q;
        fault_d      = fault_q;
        uvfb_d       = uvfb_q;
        cause_uvfb_d = cause_uvfb_q;
        detect_d     = detect_q;
        // qualification counters, restart when the level clears
        swuv_cnt_d = !swuv_s ? 10'h000 : (swuv_fault ? swuv_cnt_q : swuv_cnt_q + 10'h001);
        lnuv_cnt_d = !lnuv_s ? 10'h000 : (lnuv_fault ? lnuv_cnt_q : lnuv_cnt_q + 10'h001);
        case (state_q)
            buck_seq_pkg::ST_DETECT: begin
                probe_d = (probe_q == PROBE_LAST) ? 12'h000 : probe_q + 12'h001;
                if (crossing) begin
                    cross_d = cross_q + 3'h1;
                    // success ends probing and restarts the ramp
                    if (cross_d == buck_seq_pkg::CROSS_NEEDED) begin
                        state_d  = buck_seq_pkg::ST_SOFTST;
                        detect_d = 1'b1;
                        ss_d     = 8'h00;
                        timer_d  = 17'h00000;
                    end
                end
            end
            buck_seq_pkg::ST_SOFTST: begin
                // ramp advances one code per step interval
                // faults are not looked at here
                timer_d = timer_q + 17'h00001;
                if (timer_q >= SS_STEP_LAST) begin
                    timer_d = 17'h00000;
                    ss_d    = ss_q + 8'h01;
                    if (ss_q == buck_seq_pkg::SS_FULL - 8'h01) begin
                        state_d = buck_seq_pkg::ST_RUN;
                    end
                end
            end
            buck_seq_pkg::ST_RUN: begin
                timer_d = 17'h00000;
                if (oc_s || lnuv_fault) begin
                    fault_d      = fault_q + 3'h1;
                    cause_uvfb_d = 1'b0;
                    state_d = (fault_d == buck_seq_pkg::FAULT_LIMIT) ?
                              buck_seq_pkg::ST_LATCHED : buck_seq_pkg::ST_HICCUP;
                end else if (swuv_fault) begin
                    uvfb_d       = uvfb_q + 3'h1;
                    cause_uvfb_d = 1'b1;
                    state_d      = buck_seq_pkg::ST_HICCUP;
                end
            end
            buck_seq_pkg::ST_HICCUP: begin
                timer_d = timer_q + 17'h00001;
                if (timer_q >= HICCUP_LAST) begin
                    timer_d = 17'h00000;
                    ss_d    = 8'h00;
                    // the fourth switcher under-voltage goes back to detection
                    if (cause_uvfb_q && uvfb_q == buck_seq_pkg::UVFB_LIMIT) begin
                        state_d  = buck_seq_pkg::ST_DETECT;
                        uvfb_d   = 3'h0;
                        cross_d  = 3'h0;
                        detect_d = 1'b0;
                    end else begin
                        state_d = buck_seq_pkg::ST_SOFTST;
                    end
                end
            end
            buck_seq_pkg::ST_LATCHED: begin
                state_d = buck_seq_pkg::ST_LATCHED;
            end
            buck_seq_pkg::ST_SHUTDOWN: begin
                if (!low_s) begin
                    state_d = buck_seq_pkg::ST_DETECT;
                end
            end
            default: begin
                state_d = buck_seq_pkg::ST_SHUTDOWN;
            end
        endcase
        // pin held low overrides everything and clears the latch
        if (low_s) begin
            state_d  = buck_seq_pkg::ST_SHUTDOWN;
            cross_d  = 3'h0;
            fault_d  = 3'h0;
            uvfb_d   = 3'h0;
            ss_d     = 8'h00;
            timer_d  = 17'h00000;
            detect_d = 1'b0;
        end
        // no switching until the ramp clears the valley
        sw_en_d = (state_d == buck_seq_pkg::ST_RUN) ||
                  (state_d == buck_seq_pkg::ST_SOFTST && ss_d >= buck_seq_pkg::SS_VALLEY);
        // probe pulses only while the supply is unconfirmed
        gate_d  = (state_d == buck_seq_pkg::ST_DETECT) ? (probe_d < PROBE_HIGH)
                                                       : (sw_en_d && pwm_s);
        latch_d = (state_d == buck_seq_pkg::ST_LATCHED);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q      <= '0;
            sync2_q      <= '0;
            state_q      <= buck_seq_pkg::ST_DETECT;
            above_prev_q <= 1'b0;
            cross_q      <= 3'h0;
            probe_q      <= PROBE_LAST;
            timer_q      <= 17'h00000;
            ss_q         <= 8'h00;
            swuv_cnt_q   <= 10'h000;
            lnuv_cnt_q   <= 10'h000;
            fault_q      <= 3'h0;
            uvfb_q       <= 3'h0;
            cause_uvfb_q <= 1'b0;
            gate_q       <= 1'b0;
            sw_en_q      <= 1'b0;
            detect_q     <= 1'b0;
            latch_q      <= 1'b0;
        end else begin
            sync1_q      <= {modulator_pwm, linear_feedback_low, switcher_feedback_low,
                             overcurrent_guard, ops_pulled_low, ops_above_threshold};
            sync2_q      <= sync1_q;
            state_q      <= state_d;
            above_prev_q <= above_prev_d;
            cross_q      <= cross_d;
            probe_q      <= probe_d;
            timer_q      <= timer_d;
            ss_q         <= ss_d;
            swuv_cnt_q   <= swuv_cnt_d;
            lnuv_cnt_q   <= lnuv_cnt_d;
            fault_q      <= fault_d;
            uvfb_q       <= uvfb_d;
            cause_uvfb_q <= cause_uvfb_d;
            gate_q       <= gate_d;
            sw_en_q      <= sw_en_d;
            detect_q     <= detect_d;
            latch_q      <= latch_d;
        end
    end

    assign high_side_gate_drive = gate_q;
    assign switching_enable     = sw_en_q;
    assign soft_start_level     = ss_q;
    assign input_supply_detect  = detect_q;
    assign latched_off          = latch_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_probe_rise;
        state_q == buck_seq_pkg::ST_DETECT && $rose(gate_q);
    endsequence
    property p_probe_width;
        s_probe_rise |-> ##25 (!gate_q || state_q != buck_seq_pkg::ST_DETECT);
    endproperty
    a_probe_width: assert property (p_probe_width)
        else $error("probe pulse width wrong");
    property p_four_cross;
        $rose(detect_q) |-> $past(cross_q) == 3'h3 && $past(crossing);
    endproperty
    a_four_cross: assert property (p_four_cross)
        else $error("supply ready without four crossings");
    property p_shutdown;
        low_s |=> !sw_en_q && state_q == buck_seq_pkg::ST_SHUTDOWN;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("switching while pin held low");
    property p_ss_done;
        state_q == buck_seq_pkg::ST_RUN && $past(state_q) == buck_seq_pkg::ST_SOFTST
            |-> ss_q == buck_seq_pkg::SS_FULL;
    endproperty
    a_ss_done: assert property (p_ss_done)
        else $error("run entered before ramp complete");
    property p_valley;
        ss_q < buck_seq_pkg::SS_VALLEY && state_q != buck_seq_pkg::ST_RUN
            |-> !sw_en_q && (state_q == buck_seq_pkg::ST_DETECT || !gate_q);
    endproperty
    a_valley: assert property (p_valley)
        else $error("switching below ramp valley");
    property p_uv_delay;
        swuv_fault |-> $past(swuv_s, 8) &&
            $past(swuv_cnt_q, 1) >= buck_seq_pkg::UV_DELAY - 10'h001;
    endproperty
    a_uv_delay: assert property (p_uv_delay)
        else $error("under-voltage qualified too early");
    sequence s_off_next;
        state_q == buck_seq_pkg::ST_HICCUP && !sw_en_q;
    endsequence
    property p_hiccup;
        state_q == buck_seq_pkg::ST_RUN && !low_s && oc_s && fault_q < 3'h3 |=> s_off_next;
    endproperty
    a_hiccup: assert property (p_hiccup)
        else $error("fault did not start hiccup");
    property p_latch;
        state_q == buck_seq_pkg::ST_RUN && !low_s && lnuv_fault && fault_q == 3'h3
            |=> latch_q ##1 latch_q;
    endproperty
    a_latch: assert property (p_latch)
        else $error("fourth fault did not latch off");
    property p_ss_blind;
        state_q == buck_seq_pkg::ST_SOFTST |=> state_q != buck_seq_pkg::ST_HICCUP;
    endproperty
    a_ss_blind: assert property (p_ss_blind)
        else $error("hiccup during soft-start");
    property p_uvfb_redetect;
        state_q == buck_seq_pkg::ST_HICCUP && !low_s && timer_q >= HICCUP_LAST
            && cause_uvfb_q && uvfb_q == buck_seq_pkg::UVFB_LIMIT
            |=> state_q == buck_seq_pkg::ST_DETECT;
    endproperty
    a_uvfb_redetect: assert property (p_uvfb_redetect)
        else $error("no return to detection after four hiccups");
    property p_restart;
        $rose(detect_q) |-> state_q == buck_seq_pkg::ST_SOFTST && ss_q == 8'h00 && !gate_q;
    endproperty
    a_restart: assert property (p_restart)
        else $error("detection success did not restart ramp");
endmodule

//--- verif/power_stage_model.sv
// behavioural power stage: sense pin, fault comparators and modulator pulse
`timescale 1ns/100ps
module power_stage_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // bench controls
    input  wire logic       load,
    input  wire logic [2:0] n_cross,
    input  wire logic       shutdown_req,
    input  wire logic       oc_req,
    input  wire logic       swuv_req,
    input  wire logic       lnuv_req,
    // block side
    input  wire logic       high_side_gate_drive,
    output logic            ops_above_threshold,
    output logic            ops_pulled_low,
    output logic            overcurrent_guard,
    output logic            switcher_feedback_low,
    output logic            linear_feedback_low,
    output logic            modulator_pwm
);
    logic [2:0] left_q;
    logic       gate_q;
    logic [6:0] pwm_q;
    assign ops_pulled_low        = shutdown_req;
    assign overcurrent_guard     = oc_req;
    assign switcher_feedback_low = swuv_req;
    assign linear_feedback_low   = lnuv_req;
    // free-running modulator near 300 kHz, about a third on
    assign modulator_pwm         = (pwm_q < 7'h1c);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_q <= 3'h0;
            gate_q <= 1'b0;
            pwm_q <= 7'h0;
            ops_above_threshold <= 1'b0;
        end else begin
            gate_q <= high_side_gate_drive;
            pwm_q <= (pwm_q == 7'h52) ? 7'h0 : pwm_q + 7'h1;
            if (load)
                left_q <= n_cross;
            // a grounded pin sits below the threshold
            if (shutdown_req)
                ops_above_threshold <= 1'b0;
            // each probe pulse moves the pin across the threshold once while loaded crossings remain
            else if (high_side_gate_drive && !gate_q && left_q != 3'h0 && !load) begin
                ops_above_threshold <= !ops_above_threshold;
                left_q <= left_q - 3'h1;
            end
        end
    end
endmodule

//--- verif/buck_fault_sequencer_tb_top.sv
// self-checking bench for the buck start-up and fault sequencer
`timescale 1ns/100ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module buck_fault_sequencer_tb_top;
    localparam int SS_CYC = 2560;
    logic       clk, rst_n, load, shutdown, oc, swuv, lnuv;
    logic [2:0] n_cross;
    logic       above, pulled, ocg, swl, lnl, pwm, gate, en, det, latched;
    logic [7:0] level;
    logic [2:0] stat, stat_q;
    logic [2:0] exp_q[$];
    logic [2:0] pwm_h;
    int         n_mismatch, num_checks;
    assign stat = {det, en, latched};
    // small counts keep the run short; expectations derive from these
    buck_fault_sequencer #(.SS_TIME_CYC(SS_CYC), .HICCUP_CYC(50)) dut (
        .clk(clk), .rst_n(rst_n), .ops_above_threshold(above), .ops_pulled_low(pulled),
        .overcurrent_guard(ocg), .switcher_feedback_low(swl), .linear_feedback_low(lnl),
        .modulator_pwm(pwm), .high_side_gate_drive(gate), .switching_enable(en),
        .soft_start_level(level), .input_supply_detect(det), .latched_off(latched));
    power_stage_model stage (
        .clk(clk), .rst_n(rst_n), .load(load), .n_cross(n_cross), .shutdown_req(shutdown),
        .oc_req(oc), .swuv_req(swuv), .lnuv_req(lnuv), .high_side_gate_drive(gate),
        .ops_above_threshold(above), .ops_pulled_low(pulled), .overcurrent_guard(ocg),
        .switcher_feedback_low(swl), .linear_feedback_low(lnl), .modulator_pwm(pwm));
    always #20 clk = ~clk;
    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // which: 0 enable, 1 detect, 2 full ramp, 3 gate
    task automatic wait_sig(input int which, input logic val, input int lim, output int n);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit && n < lim) begin
            @(negedge clk);
            n++;
            case (which)
                0: hit = (en === val);
                1: hit = (det === val);
                2: hit = (level === 8'hff);
                default: hit = (gate === val);
            endcase
        end
        if (!hit) begin
            n_mismatch++;
            end_of_test();
        end
    endtask
    task automatic set_cross(input logic [2:0] v);
        @(posedge clk);
        n_cross <= v;
        load <= 1'b1;
        @(posedge clk);
        load <= 1'b0;
    endtask
    // hold 0 keeps the fault until switching stops
    task automatic fault(input int sel, input int hold);
        int n;
        @(posedge clk);
        case (sel)
            0: oc <= 1'b1;
            1: lnuv <= 1'b1;
            default: swuv <= 1'b1;
        endcase
        if (hold > 0)
            cyc(hold);
        else
            wait_sig(0, 1'b0, 1000, n);
        @(posedge clk);
        oc <= 1'b0;
        lnuv <= 1'b0;
        swuv <= 1'b0;
    endtask
    task automatic startup();
        int n;
        exp_q.push_back(3'h4);
        exp_q.push_back(3'h6);
        set_cross(3'h4);
        wait_sig(1, 1'b1, 12000, n);
        wait_sig(0, 1'b1, 3000, n);
        wait_sig(2, 1'b1, 3000, n);
    endtask
    // result watcher: every status change takes the oldest note
    always @(negedge clk) begin
        if (rst_n && stat !== stat_q) begin
            if (exp_q.size() == 0) `CHK(stat, 3'hx)
            else `CHK(stat, exp_q.pop_front())
            if (en && !stat_q[1])
                `CHK((level - buck_seq_pkg::SS_VALLEY) < 8'h2, 1'b1)
        end
        if (rst_n && ((det && !en) || latched))
            `CHK(gate, 1'b0)
        // modulator reaches the gate three edges late, through the pin synchroniser
        if (rst_n && en)
            `CHK(gate, pwm_h[2])
        pwm_h <= {pwm_h[1:0], pwm};
        stat_q <= stat;
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        int n, hi, lo, part;
        longint t0;
        clk = 1'b0;
        rst_n = 1'b0;
        load = 1'b0;
        n_cross = 3'h0;
        shutdown = 1'b0;
        oc = 1'b0;
        swuv = 1'b0;
        lnuv = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        void'($urandom(39203));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wait_sig(3, 1'b1, 3000, n);
        wait_sig(3, 1'b0, 3000, hi);
        wait_sig(3, 1'b1, 3000, lo);
        `CHK(hi, buck_seq_pkg::PROBE_HIGH_CYC)
        `CHK(hi + lo, buck_seq_pkg::PROBE_PERIOD_CYC)
        // fewer than four crossings are not enough; fault noise meanwhile is refused
        part = 1 + $urandom % 3;
        set_cross(3'(part));
        repeat (8000) begin
            @(posedge clk);
            {oc, swuv, lnuv} <= 3'($urandom);
        end
        @(posedge clk);
        {oc, swuv, lnuv} <= 3'h0;
        @(negedge clk);
        `CHK(det, 1'b0)
        exp_q.push_back(3'h4);
        exp_q.push_back(3'h6);
        set_cross(3'(4 - part));
        wait_sig(1, 1'b1, 8000, n);
        t0 = $time;
        `CHK(level, 8'h0)
        wait_sig(0, 1'b1, 3000, n);
        // over-current during the ramp must not start a hiccup
        fault(0, 3 + $urandom % 8);
        wait_sig(2, 1'b1, 3000, n);
        `CHK((($time - t0) / 40 - 255 * (SS_CYC / 256)) + 10 < 21, 1'b1)
        for (int k = 0; k < 4; k++) begin
            // a dip shorter than the qualification delay is ignored
            if (k == 1)
                fault(1, 600 + $urandom % 140);
            exp_q.push_back(k < 3 ? 3'h4 : 3'h5);
            if (k < 3)
                exp_q.push_back(3'h6);
            fault(k % 2, 0);
            if (k < 3) begin
                wait_sig(0, 1'b1, 3000, n);
                wait_sig(2, 1'b1, 3000, n);
            end
        end
        fault(0, 6);
        cyc(300);
        @(negedge clk);
        `CHK({latched, en}, 2'h2)
        exp_q.push_back(3'h0);
        @(posedge clk);
        shutdown <= 1'b1;
        cyc(20);
        @(negedge clk);
        `CHK({gate, level}, 9'h0)
        @(posedge clk);
        shutdown <= 1'b0;
        startup();
        for (int k = 0; k < 4; k++) begin
            exp_q.push_back(3'h4);
            exp_q.push_back(k < 3 ? 3'h6 : 3'h0);
            fault(2, 0);
            if (k < 3) begin
                wait_sig(0, 1'b1, 3000, n);
                wait_sig(2, 1'b1, 3000, n);
            end else
                wait_sig(1, 1'b0, 300, n);
        end
        startup();
        cyc(20);
        `CHK(exp_q.size(), 0)
        end_of_test();
    end
endmodule
